// [core/crc_map.svh]
// Register map, field positions and reset values of the DMA CRC engine
// How it works
// (RULE_01) In append mode the assigned channel's data only feeds the CRC and at block end the CRC is written to the channel's destination start address.
// (RULE_02) With append mode clear each datum goes through the CRC and on to the destination in the chosen byte order.
// (RULE_03) The algorithm select bit picks the IP header checksum when 1 and the LFSR CRC when 0.
// (RULE_04) A three-bit channel field ties the engine to exactly one of channels 0 to 7.
// (RULE_05) While the write byte order bit is 1 the append mode bit cannot be set.
// (RULE_06) A software write to the data register seeds the CRC generator.
// (RULE_07) Reading the data register gives the running CRC with bits above the polynomial length as zero.
// (RULE_08) In checksum mode only the low sixteen bits carry the checksum and the high sixteen read zero.
// (RULE_09) In checksum mode written values are converted and reads give the checksum in ones-complement form.
// (RULE_10) In LFSR mode a tap bit of 1 feeds the feedback into that stage and a 0 shifts the prior stage straight in.
// (RULE_11) In checksum mode the tap register plays no part.
// (RULE_12) The engine steps once per element of the assigned channel and ignores all other channels.
`ifndef CRC_MAP_SVH
`define CRC_MAP_SVH

// Byte offsets on the register bus
`define CRC_CTRL_OFS 4'h0
`define CRC_DATA_OFS 4'h4
`define CRC_TAPS_OFS 4'h8

// Control register field positions
`define CRC_CH_LSB 0
`define CRC_CH_MSB 2
`define CRC_TYP_BIT 5
`define CRC_APP_BIT 6
`define CRC_WBO_BIT 7

// Reset values
`define CRC_CTRL_RST 32'h0000_0000
`define CRC_DATA_RST 32'h0000_0000
`define CRC_TAPS_RST 32'h0000_0000

`endif

// [core/crc_pkg.sv]
// Types shared by the DMA CRC engine and its testbench
package crc_pkg;

  // Control register contents
  typedef struct packed {
    logic writeByteOrder;
    logic appendMode;
    logic algorithmSelect;
    logic [2:0] channelSelect;
  } ctrl_type;

  // One element moved by a DMA channel
  typedef struct packed {
    logic [31:0] data;
    logic [31:0] destAddr;
    logic [2:0] channel;
    logic last;
  } elem_type;

  // One destination write
  typedef struct packed {
    logic valid;
    logic isCrc;
    logic [31:0] addr;
    logic [31:0] data;
  } dest_type;

  // Whole state of the top module
  typedef struct packed {
    ctrl_type ctrl;
    logic [31:0] crc;
    logic [31:0] taps;
    logic waitReq;
    logic [31:0] readData;
    dest_type dest;
  } state_type;

endpackage

// [core/crc_fifo.sv]
// Parameterised flip-flop FIFO with valid and ready on both sides
module crc_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [CW-1:0] count;
    logic ready;
    logic valid;
  } fifo_state_type;

  fifo_state_type s_q, s_d;
  logic push, pop;

  assign push = inValid && s_q.ready;
  assign pop = s_q.valid && outReady;

  // Pointer, count and flag update
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wrPtr] = inData;
      s_d.wrPtr = (s_q.wrPtr == AW'(DEPTH - 1)) ? '0 : s_q.wrPtr + AW'(1);
    end
    if (pop) begin
      s_d.rdPtr = (s_q.rdPtr == AW'(DEPTH - 1)) ? '0 : s_q.rdPtr + AW'(1);
    end
    if (push && !pop) begin
      s_d.count = s_q.count + CW'(1);
    end else if (pop && !push) begin
      s_d.count = s_q.count - CW'(1);
    end
    s_d.ready = s_d.count != CW'(DEPTH);
    s_d.valid = s_d.count != '0;
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.ready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign inReady = s_q.ready;
  assign outValid = s_q.valid;
  assign outData = s_q.mem[s_q.rdPtr];
endmodule

// [core/dma_crc_generator.sv]
// DMA CRC and checksum engine with Avalon-MM registers and buffered data path
`include "crc_map.svh"

module dma_crc_generator #(
  parameter int POLY_LEN = 32,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic inValid,
  input wire crc_pkg::elem_type inElem,
  output logic inReady,
  output crc_pkg::dest_type destWrite,
  input wire logic destReady
);
  import crc_pkg::*;

  localparam logic [31:0] PolyMask = 32'hffff_ffff >> (32 - POLY_LEN);

  state_type s_q, s_d;
  elem_type fifoElem;
  logic [$bits(elem_type)-1:0] fifoData;
  logic fifoValid;
  logic pop;
  logic hit;
  logic busReq;
  logic busAck;
  logic seedWrite;
  logic mapped;
  logic [31:0] crcNext;

  // Read view of the running value
  function automatic logic [31:0] readView(input logic [31:0] crc, input logic ipMode);
    if (ipMode) begin
      return {16'h0000, ~crc[15:0]}; // RULE_08 RULE_09
    end
    return crc & PolyMask; // RULE_07
  endfunction

  // One LFSR pass over a 32-bit element, MSB first
  function automatic logic [31:0] lfsrWord(input logic [31:0] crc, input logic [31:0] taps,
                                           input logic [31:0] data);
    logic [31:0] r;
    logic fb;
    r = crc;
    for (int i = 31; i >= 0; i--) begin
      fb = r[POLY_LEN-1] ^ data[i];
      r = {r[30:0], 1'b0} ^ (taps & {32{fb}}); // RULE_10
    end
    return r & PolyMask;
  endfunction

  // Ones-complement 16-bit add with end-around carry
  function automatic logic [15:0] onesAdd(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] t;
    t = {1'b0, a} + {1'b0, b};
    return t[15:0] + {15'h0000, t[16]};
  endfunction

  // Byte order applied to pass-through writes
  function automatic logic [31:0] orderBytes(input logic [31:0] d, input logic swap);
    return swap ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
  endfunction

  // Data buffer between the channel engine and the CRC
  crc_fifo #(
    .WIDTH($bits(elem_type)),
    .DEPTH(FIFO_DEPTH)
  ) dataBuffer (
    .clk(clk),
    .rst(rst),
    .inValid(inValid),
    .inData(inElem),
    .inReady(inReady),
    .outValid(fifoValid),
    .outData(fifoData),
    .outReady(pop)
  );

  assign fifoElem = elem_type'(fifoData);

  // Drain when the destination stage is free
  assign pop = fifoValid && (!s_q.dest.valid || destReady);
  assign hit = pop && (fifoElem.channel == s_q.ctrl.channelSelect); // RULE_04 RULE_12
  assign busReq = read || write;
  assign busAck = busReq && !s_q.waitReq;

  // Decodes watched by the checks below
  assign seedWrite = busAck && write && (address == `CRC_DATA_OFS);
  assign mapped = (address == `CRC_CTRL_OFS) || (address == `CRC_DATA_OFS)
      || (address == `CRC_TAPS_OFS);

  // Algorithm step for the current element
  always_comb begin
    if (s_q.ctrl.algorithmSelect) begin
      // Taps unused here
      crcNext = {16'h0000, onesAdd(onesAdd(s_q.crc[15:0], fifoElem.data[31:16]),
                                   fifoElem.data[15:0])}; // RULE_03 RULE_11
    end else begin
      crcNext = lfsrWord(s_q.crc, s_q.taps, fifoElem.data); // RULE_03
    end
  end

  // Next state
  always_comb begin
    s_d = s_q;
    // Bus handshake: one wait cycle, then one answer cycle
    s_d.waitReq = !(busReq && s_q.waitReq);
    if (busReq && s_q.waitReq) begin
      s_d.readData = 32'h0000_0000;
      if (read) begin
        case (address)
          `CRC_CTRL_OFS: begin
            s_d.readData[`CRC_CH_MSB:`CRC_CH_LSB] = s_q.ctrl.channelSelect;
            s_d.readData[`CRC_TYP_BIT] = s_q.ctrl.algorithmSelect;
            s_d.readData[`CRC_APP_BIT] = s_q.ctrl.appendMode;
            s_d.readData[`CRC_WBO_BIT] = s_q.ctrl.writeByteOrder;
          end
          `CRC_DATA_OFS: s_d.readData = readView(s_q.crc, s_q.ctrl.algorithmSelect);
          `CRC_TAPS_OFS: s_d.readData = s_q.taps;
          default: s_d.readData = 32'h0000_0000;
        endcase
      end
    end
    // Destination stage drains
    if (s_q.dest.valid && destReady) begin
      s_d.dest.valid = 1'b0;
    end
    // Engine step on the assigned channel only
    if (hit) begin
      s_d.crc = crcNext; // RULE_12
    end
    if (pop) begin
      if (hit && s_q.ctrl.appendMode) begin
        // Source swallowed, CRC goes out at block end
        if (fifoElem.last) begin
          s_d.dest.valid = 1'b1; // RULE_01
          s_d.dest.isCrc = 1'b1;
          s_d.dest.addr = fifoElem.destAddr;
          s_d.dest.data = readView(crcNext, s_q.ctrl.algorithmSelect);
        end
      end else begin
        s_d.dest.valid = 1'b1; // RULE_02
        s_d.dest.isCrc = 1'b0;
        s_d.dest.addr = fifoElem.destAddr;
        s_d.dest.data = orderBytes(fifoElem.data, s_q.ctrl.writeByteOrder);
      end
    end
    // Register writes; a seed write overrides an engine step
    if (busAck && write) begin
      case (address)
        `CRC_CTRL_OFS: begin
          s_d.ctrl.channelSelect = writedata[`CRC_CH_MSB:`CRC_CH_LSB]; // RULE_04
          s_d.ctrl.algorithmSelect = writedata[`CRC_TYP_BIT];
          s_d.ctrl.writeByteOrder = writedata[`CRC_WBO_BIT];
          s_d.ctrl.appendMode = writedata[`CRC_APP_BIT] && !writedata[`CRC_WBO_BIT]; // RULE_05
        end
        `CRC_DATA_OFS: begin
          if (s_q.ctrl.algorithmSelect) begin
            s_d.crc = {16'h0000, ~writedata[15:0]}; // RULE_06 RULE_09
          end else begin
            s_d.crc = writedata & PolyMask; // RULE_06
          end
        end
        `CRC_TAPS_OFS: s_d.taps = writedata;
        default: s_d.taps = s_q.taps;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.ctrl <= ctrl_type'(6'h00);
      s_q.crc <= `CRC_DATA_RST;
      s_q.taps <= `CRC_TAPS_RST;
      s_q.waitReq <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign readdata = s_q.readData;
  assign waitrequest = s_q.waitReq;
  assign destWrite = s_q.dest;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Bus request seen, then one answer cycle
  sequence busAnswer;
    busReq && s_q.waitReq ##1 !s_q.waitReq;
  endsequence

  sequence lfsrSeedWrite;
    seedWrite && !s_q.ctrl.algorithmSelect;
  endsequence

  sequence ipSeedWrite;
    seedWrite && s_q.ctrl.algorithmSelect;
  endsequence

  // Read requests captured in their wait cycle
  sequence ctrlRead;
    busReq && s_q.waitReq && read && address == `CRC_CTRL_OFS;
  endsequence

  sequence dataRead;
    busReq && s_q.waitReq && read && address == `CRC_DATA_OFS;
  endsequence

  sequence tapsRead;
    busReq && s_q.waitReq && read && address == `CRC_TAPS_OFS;
  endsequence

  sequence idleRead;
    busReq && s_q.waitReq && read && !mapped;
  endsequence

  bus_single_ack_a: assert property (busAnswer |=> s_q.waitReq)
    else $error("waitrequest low for more than one cycle");

  append_swallow_a: assert property ( // RULE_01
    hit && s_q.ctrl.appendMode && !fifoElem.last && !s_q.dest.valid |=> !s_q.dest.valid)
    else $error("append mode wrote source data to the destination");

  append_crc_out_a: assert property ( // RULE_01
    hit && s_q.ctrl.appendMode && fifoElem.last && !(busAck && write)
    |=> s_q.dest.valid && s_q.dest.isCrc && s_q.dest.addr == $past(fifoElem.destAddr)
        && s_q.dest.data == readView(s_q.crc, s_q.ctrl.algorithmSelect))
    else $error("final CRC not written to destination start address");

  pass_through_a: assert property ( // RULE_02
    pop && !(hit && s_q.ctrl.appendMode)
    |=> s_q.dest.valid && !s_q.dest.isCrc
        && s_q.dest.data == orderBytes($past(fifoElem.data), $past(s_q.ctrl.writeByteOrder)))
    else $error("pass-through datum not written in configured byte order");

  append_locked_a: assert property (s_q.ctrl.writeByteOrder |-> !s_q.ctrl.appendMode) // RULE_05
    else $error("append mode set while byte order option is 1");

  seed_load_a: assert property ( // RULE_06
    lfsrSeedWrite |=> s_q.crc == ($past(writedata) & PolyMask))
    else $error("seed write did not load the CRC");

  ip_convert_a: assert property ( // RULE_09
    ipSeedWrite
    |=> s_q.crc[15:0] == ~$past(writedata[15:0]) ##1 1'b1)
    else $error("checksum seed not converted");

  lfsr_read_mask_a: assert property ( // RULE_07
    busAck && read && address == `CRC_DATA_OFS && !s_q.ctrl.algorithmSelect
    |-> (s_q.readData & ~PolyMask) == 32'h0000_0000)
    else $error("bits above polynomial length read nonzero");

  ip_upper_zero_a: assert property ( // RULE_08
    busAck && read && address == `CRC_DATA_OFS && s_q.ctrl.algorithmSelect
    && $past(s_q.ctrl.algorithmSelect) |-> s_q.readData[31:16] == 16'h0000)
    else $error("checksum upper half read nonzero");

  other_channel_a: assert property ( // RULE_12
    pop && !hit && !(busAck && write && address == `CRC_DATA_OFS) |=> $stable(s_q.crc))
    else $error("traffic on another channel changed the CRC");

  // Bus answers and read data hold between requests
  wait_idle_a: assert property (!busReq |=> s_q.waitReq)
    else $error("waitrequest low without a request");

  read_hold_a: assert property (!(busReq && s_q.waitReq) |=> $stable(s_q.readData))
    else $error("read data changed without a new request");

  ctrl_read_zero_a: assert property (ctrlRead |=> s_q.readData[31:8] == 24'h00_0000
    && s_q.readData[4:3] == 2'h0)
    else $error("unused control bits read nonzero");

  taps_read_a: assert property (tapsRead |=> s_q.readData == $past(s_q.taps)) // RULE_10
    else $error("tap register read back wrong");

  data_read_ip_a: assert property ( // RULE_09
    dataRead |=> !$past(s_q.ctrl.algorithmSelect)
    || s_q.readData[15:0] == ~$past(s_q.crc[15:0]))
    else $error("checksum not read in ones-complement form");

  unmapped_read_a: assert property (idleRead |=> s_q.readData == 32'h0000_0000)
    else $error("unmapped address read nonzero");

  // Register writes land in the answer cycle
  ctrl_write_a: assert property ( // RULE_03 RULE_04
    busAck && write && address == `CRC_CTRL_OFS
    |=> s_q.ctrl.channelSelect == $past(writedata[`CRC_CH_MSB:`CRC_CH_LSB])
        && s_q.ctrl.algorithmSelect == $past(writedata[`CRC_TYP_BIT]))
    else $error("control write not stored");

  append_refused_a: assert property ( // RULE_05
    busAck && write && address == `CRC_CTRL_OFS && writedata[`CRC_WBO_BIT]
    |=> !s_q.ctrl.appendMode)
    else $error("append mode accepted with byte order option set");

  taps_write_a: assert property ( // RULE_10
    busAck && write && address == `CRC_TAPS_OFS |=> s_q.taps == $past(writedata))
    else $error("tap write not stored");

  unmapped_write_a: assert property (
    busAck && write && !mapped |=> $stable(s_q.ctrl) && $stable(s_q.taps))
    else $error("unmapped write changed a register");

  // Engine steps
  lfsr_tap_zero_a: assert property ( // RULE_10
    hit && !s_q.ctrl.algorithmSelect && !s_q.taps[0] && !seedWrite |=> !s_q.crc[0])
    else $error("cleared tap fed the feedback into stage zero");

  ip_upper_step_a: assert property ( // RULE_08
    hit && s_q.ctrl.algorithmSelect && !seedWrite |=> s_q.crc[31:16] == 16'h0000)
    else $error("checksum step set upper bits");

  ip_sum_step_a: assert property ( // RULE_11
    hit && s_q.ctrl.algorithmSelect && !seedWrite
    |=> s_q.crc[15:0] == onesAdd(onesAdd($past(s_q.crc[15:0]), $past(fifoElem.data[31:16])),
                                 $past(fifoElem.data[15:0])))
    else $error("checksum step wrong");

  channel_pass_a: assert property ( // RULE_04 RULE_12
    pop && fifoElem.channel != s_q.ctrl.channelSelect
    |=> s_q.dest.valid && !s_q.dest.isCrc && s_q.dest.addr == $past(fifoElem.destAddr))
    else $error("other channel element not passed through");

  // Destination stage and buffer flow control
  dest_hold_a: assert property (
    s_q.dest.valid && !destReady |=> s_q.dest.valid && $stable(s_q.dest))
    else $error("pending destination write changed before it was taken");

  stall_no_pop_a: assert property (s_q.dest.valid && !destReady |-> !pop)
    else $error("buffer drained into a stalled destination stage");

  dest_release_a: assert property (s_q.dest.valid && destReady && !pop |=> !s_q.dest.valid)
    else $error("taken destination write not released");

  inready_full_a: assert property (!inReady |-> fifoValid)
    else $error("buffer refused data while empty");
endmodule

// [dv/dma_channel_model.sv]
// Behavioural DMA channel engine that feeds elements and drains destination writes
module dma_channel_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic stall,
  input wire logic inReady,
  input wire crc_pkg::dest_type destWrite,
  output logic inValid,
  output crc_pkg::elem_type inElem,
  output logic destReady
);
  timeunit 1ns;
  timeprecision 1ns;
  import crc_pkg::*;
  elem_type pend[$];
  dest_type got[$];
  logic [1:0] beat;

  // Known values before the first edge
  initial begin
    inValid = 1'b0;
    inElem = '0;
    destReady = 1'b0;
    beat = 2'h0;
  end

  // Offer queued elements, hold each until taken, stall the destination on demand
  always @(posedge clk) begin
    if (rst) begin
      inValid <= 1'b0;
      destReady <= 1'b0;
    end else begin
      if (!inValid || inReady) begin
        if (pend.size() > 0) begin
          inValid <= 1'b1;
          inElem <= pend.pop_front();
        end else begin
          inValid <= 1'b0;
          inElem <= ~inElem; // Idle lines invert every bit each cycle, the last flag included
        end
      end
      beat <= beat + 2'h1;
      destReady <= !stall && (beat != 2'h0);
      if (destWrite.valid && destReady) got.push_back(destWrite);
    end
  end
endmodule

// [dv/dma_crc_generator_bench.sv]
// Self-checking bench for the DMA CRC engine
`define CHECK(g, e) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH %0t got %h exp %h", $time, g, e); end end

module dma_crc_generator_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import crc_pkg::*;
  localparam logic [31:0] MASK = 32'h0000ffff;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest, inValid, inReady, destReady;
  logic stall = 1'b0;
  elem_type inElem;
  dest_type destWrite;
  int mismatches = 0;
  int comparisons = 0;
  logic [31:0] rs = 32'h0000_0031;
  logic [31:0] crcE, tapsE;
  logic [15:0] sumE;
  logic typE;
  dest_type expq[$];

  // Free-running 100 MHz clock
  always #5 clk = ~clk;

  dma_crc_generator #(.POLY_LEN(16), .FIFO_DEPTH(8)) dut_u (.clk(clk), .rst(rst),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .inValid(inValid), .inElem(inElem),
    .inReady(inReady), .destWrite(destWrite), .destReady(destReady));

  dma_channel_model model_u (.clk(clk), .rst(rst), .stall(stall), .inReady(inReady),
    .destWrite(destWrite), .inValid(inValid), .inElem(inElem), .destReady(destReady));

  // Expected-value helpers
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction

  function automatic logic [31:0] lfsr(logic [31:0] c, logic [31:0] d, logic [31:0] t);
    logic fb;
    for (int b = 31; b >= 0; b--) begin
      fb = c[15] ^ d[b];
      c = ((c << 1) ^ (t & {32{fb}})) & MASK;
    end
    return c;
  endfunction

  function automatic logic [15:0] ipAdd(logic [15:0] s, logic [15:0] v);
    logic [16:0] w;
    w = s + v;
    return w[15:0] + 16'(w[16]);
  endfunction

  function automatic logic [31:0] view();
    return typE ? {16'h0, ~sumE} : crcE & MASK;
  endfunction

  task automatic print_verdict();
    if (mismatches == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // One Avalon transfer, held until waitrequest is sampled low
  task automatic busCycle(logic [3:0] a, logic wr, logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge clk);
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (waitrequest !== 1'b0) begin
      mismatches++;
      print_verdict();
    end
    r = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic chk(logic [3:0] a, logic [31:0] e);
    logic [31:0] r;
    busCycle(a, 1'b0, 32'h0, r);
    `CHECK(r, e)
  endtask

  // Configure, seed and stream one block, then compare every destination write
  task automatic runBlock(int i);
    logic [31:0] cw, r, s;
    logic [2:0] ch;
    logic app, write_byte_order;
    elem_type e;
    int n;
    ch = i[2:0];
    typE = i[3];
    app = i[0] ^ i[3];
    write_byte_order = !app && i[1];
    cw = {24'h0, write_byte_order, app, typE, 2'h0, ch};
    busCycle(4'h0, 1'b1, cw, r);
    chk(4'h0, cw);
    tapsE = rnd();
    busCycle(4'h8, 1'b1, tapsE, r);
    chk(4'h8, tapsE);
    s = rnd();
    busCycle(4'h4, 1'b1, s, r);
    crcE = s & MASK;
    sumE = ~s[15:0];
    chk(4'h4, view());
    if (i == 0) stall <= 1'b1;
    for (int k = 0; k < 12; k++) begin
      e.data = rnd();
      e.destAddr = rnd();
      e.channel = (k == 11 || rnd() % 4 != 0) ? ch : 3'(rnd());
      e.last = (k == 11);
      if (e.channel == ch && typE) sumE = ipAdd(ipAdd(sumE, e.data[31:16]), e.data[15:0]);
      if (e.channel == ch && !typE) crcE = lfsr(crcE, e.data, tapsE);
      if (e.channel != ch || !app)
        expq.push_back({2'h2, e.destAddr, write_byte_order ? {e.data[7:0], e.data[15:8],
          e.data[23:16], e.data[31:24]} : e.data});
      else if (e.last)
        expq.push_back({2'h3, e.destAddr, view()});
      model_u.pend.push_back(e);
    end
    n = 0;
    while (i == 0 && inReady !== 1'b0 && n < 200) begin
      @(posedge clk);
      n++;
    end
    if (i == 0) `CHECK(inReady, 1'b0)
    if (i == 0 && inReady !== 1'b0) print_verdict();
    stall <= 1'b0;
    n = 0;
    while (model_u.got.size() < expq.size() && n < 2000) begin
      @(posedge clk);
      n++;
    end
    `CHECK(model_u.got.size(), expq.size())
    if (model_u.got.size() < expq.size()) print_verdict();
    foreach (expq[j]) if (j < model_u.got.size()) `CHECK(model_u.got[j], expq[j])
    chk(4'h4, view());
    expq.delete();
    model_u.got.delete();
  endtask

  // Reset, register checks, then sixteen blocks over all channels and modes
  initial begin
    logic [31:0] r;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    chk(4'h0, 32'h0);
    chk(4'h4, 32'h0);
    chk(4'h8, 32'h0);
    busCycle(4'hc, 1'b1, rnd(), r);
    chk(4'hc, 32'h0);
    busCycle(4'h0, 1'b1, 32'hff, r);
    chk(4'h0, 32'ha7);
    for (int i = 0; i < 16; i++) runBlock(i);
    print_verdict();
  end
endmodule
